// File: rtl/bcb_exec.sv
// Execution unit for relative jumps, calls, bit-set and bit-test-skip
//
// Functional notes
// - Literal relative jump: PC becomes old PC plus one plus sign-extended 9-bit literal.
// - Literal offset is two's complement, range -256 to +255.
// - Both relative jumps take two cycles, discarding the fetched next word.
// - Accumulator relative jump adds unsigned accumulator to incremented PC.
// - Bit-set forces bit b of register f to one, nothing else changes.
// - Skip-when-zero replaces the next instruction with a no-op if bit is zero.
// - Skip-when-one replaces the next instruction with a no-op if bit is one.
// - A taken skip costs two cycles, the second a substituted no-op.
// - Literal call pushes its own address plus one onto the stack top.
// - Literal call loads PC[10:0] from literal and PC[14:11] from latch[6:3].
// - Literal call completes in two cycles.
// - Accumulator call pushes the incremented PC before redirecting.
// - Accumulator call loads PC[7:0] from accumulator, PC[14:8] from latch[6:0].
// - Accumulator call completes in two cycles.
`timescale 1ns/1ps
module bcb_exec (
    // Clock, reset, enable
    input  wire logic                core_clk,
    input  wire logic                rstn,
    input  wire logic                clk_en,
    // Decoded instruction from the fetch stage
    input  wire logic                instr_valid,
    input  wire bcb_pkg::bcb_instr_s instr,
    input  wire logic [14:0]         pc_cur,
    // Core state read by this group
    input  wire logic [7:0]          acc,
    input  wire logic [7:0]          pc_hi_latch,
    input  wire logic [7:0]          reg_rdata,
    // Data memory write-back
    output bcb_pkg::bcb_wr_s         reg_wr,
    // Program counter redirect and pipeline flush
    output logic                     pc_load,
    output logic [14:0]              pc_next,
    output logic                     flush_next,
    // Return stack push
    output logic                     stack_push,
    output logic [14:0]              stack_top_entry,
    // Status flag write enables (always idle for this group)
    output logic                     flags_we,
    // Cycle in progress is the forced second cycle
    output logic                     busy
);
    typedef enum logic [1:0] {
        BCB_ST_RUN,
        BCB_ST_SECOND
    } bcb_state_e;

    bcb_state_e  state_r;
    bcb_state_e  state_nxt;
    logic [14:0] pc_inc;
    logic [14:0] target;
    logic        accept;
    logic        is_redirect;
    logic        is_call;
    logic        is_skip_op;
    logic        sel_bit;
    logic        skip_taken;
    logic        two_cycle;
    bcb_pkg::bcb_wr_s wr_nxt;

    // Set one bit without disturbing its neighbours
    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction : bit_mask

    // Instruction decode; a new one is only taken in the running state
    assign accept      = clk_en && instr_valid && (state_r == BCB_ST_RUN);
    assign pc_inc      = pc_cur + 15'h0001;
    assign is_call     = (instr.op == bcb_pkg::BCB_OP_CALL_LIT) ||
                         (instr.op == bcb_pkg::BCB_OP_CALL_ACC);
    assign is_redirect = is_call || (instr.op == bcb_pkg::BCB_OP_REL_LIT) ||
                         (instr.op == bcb_pkg::BCB_OP_REL_ACC);
    assign is_skip_op  = (instr.op == bcb_pkg::BCB_OP_SKIP_ZERO) ||
                         (instr.op == bcb_pkg::BCB_OP_SKIP_ONE);
    assign sel_bit     = reg_rdata[instr.bit_idx];
    // Skip when the selected bit matches the sense of the test
    assign skip_taken  = ((instr.op == bcb_pkg::BCB_OP_SKIP_ZERO) && !sel_bit) ||
                         ((instr.op == bcb_pkg::BCB_OP_SKIP_ONE) && sel_bit);
    assign two_cycle   = accept && (is_redirect || skip_taken);

    // Target arithmetic kept in its own module
    bcb_target u_target (
        .instr       (instr),
        .pc_inc      (pc_inc),
        .acc         (acc),
        .pc_hi_latch (pc_hi_latch),
        .target      (target)
    );

    // Redirect and flush are combinational handshakes with the fetch stage
    assign pc_load         = accept && is_redirect;
    assign pc_next         = target;
    assign flush_next      = two_cycle;
    // Return address is always the incremented PC, pushed before redirect
    assign stack_push      = accept && is_call;
    assign stack_top_entry = pc_inc;
    // This group never writes status flags
    assign flags_we        = 1'b0;
    assign busy            = (state_r == BCB_ST_SECOND);

    // Bit-set write data: read-modify-write of the addressed register
    assign wr_nxt.we   = accept && (instr.op == bcb_pkg::BCB_OP_BIT_SET);
    assign wr_nxt.addr = instr.reg_addr;
    assign wr_nxt.data = reg_rdata | bit_mask(instr.bit_idx);

    // Second cycle is a no-op slot; nothing new is accepted during it
    always_comb begin
        case (state_r)
            BCB_ST_RUN:    state_nxt = two_cycle ? BCB_ST_SECOND : BCB_ST_RUN;
            BCB_ST_SECOND: state_nxt = clk_en ? BCB_ST_RUN : BCB_ST_SECOND;
            default:       state_nxt = BCB_ST_RUN;
        endcase
    end

    // Cycle state register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= BCB_ST_RUN;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    // Write-back is registered so the memory sees stable data
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_wr <= '0;
        end else if (clk_en) begin
            reg_wr <= wr_nxt;
        end
    end

    // Helper: target used by a literal call, for checking
    wire logic [14:0] chk_call_lit = {pc_hi_latch[6:3], instr.call_k};

    property p_rel_lit;
        @(posedge core_clk) disable iff (!rstn)
        (accept && instr.op == bcb_pkg::BCB_OP_REL_LIT) |->
            pc_load && pc_next == 15'(pc_cur + 15'h0001 + {{6{instr.rel_k[8]}}, instr.rel_k});
    endproperty
    a_rel_lit: assert property (p_rel_lit) else $error("literal jump target wrong");

    property p_rel_range;
        @(posedge core_clk) disable iff (!rstn)
        (accept && instr.op == bcb_pkg::BCB_OP_REL_LIT && instr.rel_k == 9'h100) |->
            pc_next == 15'(pc_cur - 15'h00ff);
    endproperty
    a_rel_range: assert property (p_rel_range) else $error("offset -256 wrong");

    property p_two_cycle;
        @(posedge core_clk) disable iff (!rstn)
        (accept && is_redirect && clk_en) |=> busy ##1 (!busy || !$past(clk_en));
    endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("jump not two cycles");

    property p_rel_acc;
        @(posedge core_clk) disable iff (!rstn)
        (accept && instr.op == bcb_pkg::BCB_OP_REL_ACC) |->
            pc_next == 15'(pc_cur + 15'h0001 + {7'h00, acc});
    endproperty
    a_rel_acc: assert property (p_rel_acc) else $error("accumulator jump wrong");

    property p_bit_set;
        @(posedge core_clk) disable iff (!rstn)
        (clk_en && accept && instr.op == bcb_pkg::BCB_OP_BIT_SET) |=>
            reg_wr.we && reg_wr.data == ($past(reg_rdata) | (8'h01 << $past(instr.bit_idx)));
    endproperty
    a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

    property p_skip_zero;
        @(posedge core_clk) disable iff (!rstn)
        (accept && instr.op == bcb_pkg::BCB_OP_SKIP_ZERO) |-> (flush_next == !sel_bit);
    endproperty
    a_skip_zero: assert property (p_skip_zero) else $error("skip on zero wrong");

    property p_skip_one;
        @(posedge core_clk) disable iff (!rstn)
        (accept && instr.op == bcb_pkg::BCB_OP_SKIP_ONE) |-> (flush_next == sel_bit);
    endproperty
    a_skip_one: assert property (p_skip_one) else $error("skip on one wrong");

    property p_skip_cycles;
        @(posedge core_clk) disable iff (!rstn)
        (accept && is_skip_op && skip_taken && clk_en) |=> busy && !pc_load;
    endproperty
    a_skip_cycles: assert property (p_skip_cycles) else $error("skip not two cycles");

    property p_call_push;
        @(posedge core_clk) disable iff (!rstn)
        (accept && is_call) |-> stack_push && stack_top_entry == 15'(pc_cur + 15'h0001);
    endproperty
    a_call_push: assert property (p_call_push) else $error("return address wrong");

    property p_call_lit;
        @(posedge core_clk) disable iff (!rstn)
        (accept && instr.op == bcb_pkg::BCB_OP_CALL_LIT) |-> pc_next == chk_call_lit;
    endproperty
    a_call_lit: assert property (p_call_lit) else $error("literal call target wrong");

    property p_call_acc;
        @(posedge core_clk) disable iff (!rstn)
        (accept && instr.op == bcb_pkg::BCB_OP_CALL_ACC) |->
            pc_next == {pc_hi_latch[6:0], acc} && stack_push;
    endproperty
    a_call_acc: assert property (p_call_acc) else $error("accumulator call wrong");

    property p_no_accept_busy;
        @(posedge core_clk) disable iff (!rstn)
        busy |-> !pc_load && !stack_push && !flush_next;
    endproperty
    a_no_accept_busy: assert property (p_no_accept_busy) else $error("issued in no-op slot");

    property p_flags;
        @(posedge core_clk) disable iff (!rstn)
        instr_valid |-> !flags_we;
    endproperty
    a_flags: assert property (p_flags) else $error("flags written");
endmodule : bcb_exec

// File: rtl/bcb_pkg.sv
// Package for the branch, call and bit-test execution block
package bcb_pkg;

    // Widths
    localparam int PC_W    = 15;
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 7;
    localparam int BIT_W   = 3;
    localparam int REL_W   = 9;
    localparam int LIT_W   = 11;

    // Field positions
    localparam int LIT_LO_HI   = 10;  // Literal call target PC[10:0]
    localparam int LATH_CALL_L = 3;   // High latch bits 6..3 for literal call
    localparam int LATH_CALL_H = 6;

    // Reset values
    localparam logic [14:0] PC_RST = 15'h0000;

    // Instruction classes handed to the block by the decoder
    typedef enum logic [3:0] {
        BCB_OP_NONE,
        BCB_OP_REL_LIT,
        BCB_OP_REL_ACC,
        BCB_OP_BIT_SET,
        BCB_OP_SKIP_ZERO,
        BCB_OP_SKIP_ONE,
        BCB_OP_CALL_LIT,
        BCB_OP_CALL_ACC
    } bcb_op_e;

    // One decoded instruction with its operands
    typedef struct packed {
        bcb_op_e     op;
        logic [8:0]  rel_k;
        logic [10:0] call_k;
        logic [6:0]  reg_addr;
        logic [2:0]  bit_idx;
    } bcb_instr_s;

    // Write-back to data memory
    typedef struct packed {
        logic       we;
        logic [6:0] addr;
        logic [7:0] data;
    } bcb_wr_s;

endpackage : bcb_pkg

// File: rtl/bcb_target.sv
// Target address computation for relative jumps and calls
`timescale 1ns/1ps
module bcb_target (
    // Operation and operands
    input  wire bcb_pkg::bcb_instr_s instr,
    input  wire logic [14:0]         pc_inc,
    input  wire logic [7:0]          acc,
    input  wire logic [7:0]          pc_hi_latch,
    // Result
    output logic [14:0]              target
);
    // Candidate targets, one per redirecting operation
    wire logic [14:0] rel_lit_tgt;
    wire logic [14:0] rel_acc_tgt;
    wire logic [14:0] call_lit_tgt;
    wire logic [14:0] call_acc_tgt;

    // Sign-extend the 9-bit offset; wraps modulo the program space
    assign rel_lit_tgt  = pc_inc + {{6{instr.rel_k[8]}}, instr.rel_k};
    // Accumulator taken as unsigned, zero-extended
    assign rel_acc_tgt  = pc_inc + {7'h00, acc};
    // Literal call latch field positions come from the package; chk_call_lit in bcb_exec hard-codes [6:3]
    assign call_lit_tgt = {pc_hi_latch[bcb_pkg::LATH_CALL_H:bcb_pkg::LATH_CALL_L],
                           instr.call_k};
    assign call_acc_tgt = {pc_hi_latch[6:0], acc};

    // Select by operation
    always_comb begin
        case (instr.op)
            bcb_pkg::BCB_OP_REL_LIT:  target = rel_lit_tgt;
            bcb_pkg::BCB_OP_REL_ACC:  target = rel_acc_tgt;
            bcb_pkg::BCB_OP_CALL_LIT: target = call_lit_tgt;
            bcb_pkg::BCB_OP_CALL_ACC: target = call_acc_tgt;
            default:                  target = pc_inc;
        endcase
    end
endmodule : bcb_target

// File: test/tb_branch_call_bit_test.sv
// Self-checking bench for the branch, call and bit-test execution unit
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_branch_call_bit_test;
    // Clock, reset, enable
    logic                core_clk;
    logic                rstn;
    logic                clk_en;
    // Instruction and core state
    logic                instr_valid;
    bcb_pkg::bcb_instr_s instr;
    logic [14:0]         pc_cur;
    logic [7:0]          acc;
    logic [7:0]          pc_hi_latch;
    logic [7:0]          reg_rdata;
    // Observed outputs
    bcb_pkg::bcb_wr_s    reg_wr;
    logic                pc_load;
    logic [14:0]         pc_next;
    logic                flush_next;
    logic                stack_push;
    logic [14:0]         stack_top_entry;
    logic                flags_we;
    logic                busy;
    int                  n_mismatch;
    int                  checks_done;
    int                  cycles;

    bcb_exec u_dut (
        .core_clk        (core_clk),
        .rstn            (rstn),
        .clk_en          (clk_en),
        .instr_valid     (instr_valid),
        .instr           (instr),
        .pc_cur          (pc_cur),
        .acc             (acc),
        .pc_hi_latch     (pc_hi_latch),
        .reg_rdata       (reg_rdata),
        .reg_wr          (reg_wr),
        .pc_load         (pc_load),
        .pc_next         (pc_next),
        .flush_next      (flush_next),
        .stack_push      (stack_push),
        .stack_top_entry (stack_top_entry),
        .flags_we        (flags_we),
        .busy            (busy)
    );

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    // Hang guard; the full sequence needs well under a hundred cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles >= 400) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // Empty slot; also fills the forbidden cycle after a two-cycle op
    task automatic idle();
        @(negedge core_clk);
        instr_valid = 1'b0;
        instr.op    = bcb_pkg::BCB_OP_NONE;
        #1;
    endtask : idle

    // Present one instruction, judge the same-cycle and next-cycle answers
    task automatic run_op(input bcb_pkg::bcb_op_e op, input logic [8:0] rk,
            input logic [10:0] ck, input logic [6:0] ra, input logic [2:0] bi,
            input logic load, input logic flush, input logic push,
            input logic [14:0] nxt, input bcb_pkg::bcb_wr_s wr);
        logic [14:0] ret;
        ret = pc_cur + 15'h0001;
        @(negedge core_clk);
        instr_valid = 1'b1;
        instr       = {op, rk, ck, ra, bi};
        #1;
        `CHK(pc_load, load)
        `CHK(flush_next, flush)
        `CHK(stack_push, push)
        if (load) `CHK(pc_next, nxt)
        if (push) `CHK(stack_top_entry, ret)
        `CHK(flags_we, 1'b0)
        idle();
        `CHK(busy, flush)
        // Address and data lines carry don't-care values while no write is strobed
        `CHK(reg_wr.we, wr.we)
        if (wr.we) `CHK(reg_wr, wr)
        idle();
        `CHK(busy, 1'b0)
        // Return on a falling edge so the caller's setup lands there too
        @(negedge core_clk);
    endtask : run_op

    // Offset extremes, and an accumulator jump that wraps the counter
    task automatic t_rel_jumps();
        pc_cur = 15'h0200;
        run_op(bcb_pkg::BCB_OP_REL_LIT, 9'h100, 11'h000, 7'h00, 3'h0, 1'b1, 1'b1, 1'b0,
            15'h0101, '0);
        run_op(bcb_pkg::BCB_OP_REL_LIT, 9'h0ff, 11'h000, 7'h00, 3'h0, 1'b1, 1'b1, 1'b0,
            15'h0300, '0);
        pc_cur = 15'h7f80;
        acc    = 8'hff;
        run_op(bcb_pkg::BCB_OP_REL_ACC, 9'h1ff, 11'h000, 7'h00, 3'h0, 1'b1, 1'b1, 1'b0,
            15'h0080, '0);
    endtask : t_rel_jumps

    // Highest and lowest address and bit index
    task automatic t_bit_set();
        reg_rdata = 8'h5a;
        run_op(bcb_pkg::BCB_OP_BIT_SET, 9'h000, 11'h000, 7'h7f, 3'h7, 1'b0, 1'b0, 1'b0,
            15'h0000, {1'b1, 7'h7f, 8'hda});
        run_op(bcb_pkg::BCB_OP_BIT_SET, 9'h000, 11'h000, 7'h00, 3'h0, 1'b0, 1'b0, 1'b0,
            15'h0000, {1'b1, 7'h00, 8'h5b});
    endtask : t_bit_set

    // Both tests against both bit values; neighbours hold the opposite value
    task automatic t_skips();
        bcb_pkg::bcb_op_e op;
        logic             taken;
        for (int i = 0; i < 4; i++) begin
            op        = (i < 2) ? bcb_pkg::BCB_OP_SKIP_ZERO : bcb_pkg::BCB_OP_SKIP_ONE;
            reg_rdata = i[0] ? 8'h08 : 8'hf7;
            taken     = (i < 2) ? ~i[0] : i[0];
            run_op(op, 9'h000, 11'h000, 7'h15, 3'h3, 1'b0, taken, 1'b0,
                15'h0000, '0);
        end
    endtask : t_skips

    // Latch bit 7 and, for the literal call, bit 0 lie outside the used field and are set so a wrong slice shows
    task automatic t_calls();
        pc_cur      = 15'h1234;
        pc_hi_latch = 8'hc9;
        run_op(bcb_pkg::BCB_OP_CALL_LIT, 9'h000, 11'h5a5, 7'h00, 3'h0, 1'b1, 1'b1, 1'b1,
            15'h4da5, '0);
        acc         = 8'h3c;
        pc_hi_latch = 8'hd5;
        run_op(bcb_pkg::BCB_OP_CALL_ACC, 9'h000, 11'h000, 7'h00, 3'h0, 1'b1, 1'b1, 1'b1,
            15'h553c, '0);
    endtask : t_calls

    // A call offered in the forced slot is ignored; a frozen edge accepts nothing
    task automatic t_refuse_freeze();
        pc_cur = 15'h0040;
        @(negedge core_clk);
        instr_valid = 1'b1;
        instr       = {bcb_pkg::BCB_OP_CALL_ACC, 9'h000, 11'h000, 7'h00, 3'h0};
        @(negedge core_clk);
        instr.op = bcb_pkg::BCB_OP_CALL_LIT;
        #1;
        `CHK(busy, 1'b1)
        `CHK(stack_push, 1'b0)
        `CHK(pc_load, 1'b0)
        idle();
        `CHK(busy, 1'b0)
        @(negedge core_clk);
        clk_en      = 1'b0;
        reg_rdata   = 8'h00;
        instr_valid = 1'b1;
        instr       = {bcb_pkg::BCB_OP_BIT_SET, 9'h000, 11'h000, 7'h22, 3'h1};
        @(negedge core_clk);
        #1;
        `CHK(reg_wr.we, 1'b0)
        @(negedge core_clk);
        clk_en = 1'b1;
        idle();
        `CHK(reg_wr, bcb_pkg::bcb_wr_s'({1'b1, 7'h22, 8'h02}))
    endtask : t_refuse_freeze

    // Main sequence
    initial begin
        core_clk    = 1'b0;
        rstn        = 1'b0;
        clk_en      = 1'b1;
        instr_valid = 1'b0;
        instr       = '0;
        pc_cur      = 15'h0000;
        acc         = 8'h00;
        pc_hi_latch = 8'h00;
        reg_rdata   = 8'h00;
        n_mismatch  = 0;
        checks_done = 0;
        cycles      = 0;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        t_rel_jumps();
        t_bit_set();
        t_skips();
        t_calls();
        t_refuse_freeze();
        give_verdict();
    end
endmodule : tb_branch_call_bit_test
